// ### src/losdc_defs.vh
`ifndef LOSDC_DEFS_VH
`define LOSDC_DEFS_VH
`define LOSDC_R_W        14
`define LOSDC_A_W        5
`define LOSDC_B_W        13
`define LOSDC_P          4'h8
`define LOSDC_HR_W       4
`define LOSDC_BAND_W     6
`define LOSDC_AMP_W      3
`define LOSDC_ABL_W      3
`define LOSDC_BAND_CYC   3'h5
`define LOSDC_REG_REF    2'h0
`define LOSDC_REG_FB     2'h1
`define LOSDC_REG_CTL    2'h2
`define LOSDC_REG_TEST   2'h3
`endif

// ### src/losdc_top.v
`include "losdc_defs.vh"

module losdc_top #(
    parameter R_W    = `LOSDC_R_W,
    parameter A_W    = `LOSDC_A_W,
    parameter B_W    = `LOSDC_B_W,
    parameter HR_W   = `LOSDC_HR_W,
    parameter BAND_W = `LOSDC_BAND_W,
    parameter AMP_W  = `LOSDC_AMP_W,
    parameter ABL_W  = `LOSDC_ABL_W
) (
    input  wire              clock,        // master clock
    input  wire              rst_n,        // synchronous reset, active low
    input  wire              wr_en,        // register write strobe
    input  wire [1:0]        wr_addr,      // register select 0..3
    input  wire [23:0]       wr_data,      // register write data
    input  wire              vco_clk,      // oscillator output, sampled
    input  wire              cal_fast,     // comparator: oscillator above target
    input  wire              amp_ok,       // comparator: amplitude sufficient
    output reg               ref_pulse,    // reference divider output pulse
    output reg               fb_pulse,     // feedback divider output pulse
    output reg               modulus_q,    // 1 = prescaler divide by P+1
    output reg               pfd_up,       // charge pump up
    output reg               pfd_dn,       // charge pump down
    output reg               tune_hold,    // tuning tied to internal reference
    output reg  [BAND_W-1:0] band_q,       // selected oscillator band
    output reg  [AMP_W-1:0]  amp_q,        // selected oscillator amplitude
    output reg  [HR_W-1:0]   hr_sel_q,     // half-rate divider half-steps above 2
    output reg               lo_i,         // in-phase output
    output reg               lo_q,         // quadrature output
    output reg               cal_busy      // autocalibration running
);

    // ****************************************************************
    // register storage
    // ****************************************************************
    reg [R_W-1:0]   r_div_q;
    reg [A_W-1:0]   a_val_q;
    reg [B_W-1:0]   b_val_q;
    reg [ABL_W-1:0] abl_q;
    reg             cal_start;

    always @(posedge clock) begin
        cal_start <= 1'b0;
        if (!rst_n) begin
            r_div_q <= {{(R_W-1){1'b0}}, 1'b1};
            a_val_q <= {A_W{1'b0}};
            b_val_q <= {{(B_W-2){1'b0}}, 2'h3};
            abl_q   <= {ABL_W{1'b0}};
        end else if (wr_en) begin
            case (wr_addr)
                `LOSDC_REG_REF: r_div_q <= wr_data[R_W-1:0];
                `LOSDC_REG_FB: begin
                    a_val_q <= wr_data[A_W-1:0];
                    b_val_q <= wr_data[A_W+B_W-1:A_W];
                end
                `LOSDC_REG_CTL: abl_q <= wr_data[ABL_W-1:0];
                default: cal_start <= 1'b1;
            endcase
        end
    end

    // ****************************************************************
    // reference divider
    // ****************************************************************
    reg [R_W-1:0] r_cnt_q;
    always @(posedge clock) begin
        if (!rst_n) begin
            r_cnt_q   <= {R_W{1'b0}};
            ref_pulse <= 1'b0;
        end else if (r_cnt_q + {{(R_W-1){1'b0}}, 1'b1} >= r_div_q) begin
            r_cnt_q   <= {R_W{1'b0}};
            ref_pulse <= 1'b1;
        end else begin
            r_cnt_q   <= r_cnt_q + {{(R_W-1){1'b0}}, 1'b1};
            ref_pulse <= 1'b0;
        end
    end

    // ****************************************************************
    // half-rate divider on sampled oscillator edges
    // ****************************************************************
    reg             vco_d_q;
    wire            vco_edge = vco_clk & ~vco_d_q;
    reg [HR_W+1:0]  hr_acc_q;
    reg             hr_pulse;
    wire [HR_W+1:0] hr_half = {2'h0, hr_sel_q} + 6'h4;   // ratio in half-edges
    always @(posedge clock) begin
        if (!rst_n) begin
            vco_d_q  <= 1'b0;
            hr_acc_q <= {(HR_W+2){1'b0}};
            hr_pulse <= 1'b0;
        end else begin
            vco_d_q  <= vco_clk;
            hr_pulse <= 1'b0;
            if (vco_edge) begin
                if (hr_acc_q + 6'h2 >= hr_half) begin
                    hr_acc_q <= hr_acc_q + 6'h2 - hr_half;
                    hr_pulse <= 1'b1;
                end else begin
                    hr_acc_q <= hr_acc_q + 6'h2;
                end
            end
        end
    end

    // ****************************************************************
    // quadrature divide by four
    // ****************************************************************
    reg [1:0] quad_q;
    // gray count for I and Q
    always @(posedge clock) begin
        if (!rst_n) begin
            // start one step early so the first output moves one phase only
            quad_q <= 2'h3;
            lo_i   <= 1'b0;
            lo_q   <= 1'b0;
        end else if (hr_pulse) begin
            quad_q <= quad_q + 2'h1;
            lo_i   <= (quad_q == 2'h0) | (quad_q == 2'h3);
            lo_q   <= (quad_q == 2'h0) | (quad_q == 2'h1);
        end
    end

    // ****************************************************************
    // dual-modulus prescaler and feedback counters
    // ****************************************************************
    reg [3:0]     pre_cnt_q;
    reg [A_W-1:0] a_cnt_q;
    reg [B_W-1:0] b_cnt_q;
    wire [3:0]    pre_top = modulus_q ? `LOSDC_P : (`LOSDC_P - 4'h1);
    always @(posedge clock) begin
        if (!rst_n) begin
            pre_cnt_q <= 4'h0;
            a_cnt_q   <= {A_W{1'b0}};
            b_cnt_q   <= {B_W{1'b0}};
            modulus_q <= 1'b0;
            fb_pulse  <= 1'b0;
        end else begin
            fb_pulse <= 1'b0;
            if (vco_edge) begin
                if (pre_cnt_q >= pre_top) begin
                    pre_cnt_q <= 4'h0;
                    if (b_cnt_q + {{(B_W-1){1'b0}}, 1'b1} >= b_val_q) begin
                        b_cnt_q   <= {B_W{1'b0}};
                        a_cnt_q   <= {A_W{1'b0}};
                        modulus_q <= (a_val_q != {A_W{1'b0}});
                        fb_pulse  <= 1'b1;
                    end else begin
                        b_cnt_q <= b_cnt_q + {{(B_W-1){1'b0}}, 1'b1};
                        if (modulus_q) begin
                            a_cnt_q <= a_cnt_q + {{(A_W-1){1'b0}}, 1'b1};
                            if (a_cnt_q + {{(A_W-1){1'b0}}, 1'b1} >= a_val_q)
                                modulus_q <= 1'b0;
                        end
                    end
                end else begin
                    pre_cnt_q <= pre_cnt_q + 4'h1;
                end
            end
        end
    end

    // ****************************************************************
    // phase-frequency detector with anti-backlash
    // ****************************************************************
    reg [ABL_W:0] abl_cnt_q;
    always @(posedge clock) begin
        if (!rst_n) begin
            pfd_up    <= 1'b0;
            pfd_dn    <= 1'b0;
            abl_cnt_q <= {(ABL_W+1){1'b0}};
        end else if (tune_hold) begin
            pfd_up    <= 1'b0;
            pfd_dn    <= 1'b0;
            abl_cnt_q <= {(ABL_W+1){1'b0}};
        end else if (pfd_up & pfd_dn) begin
            if (abl_cnt_q >= {1'b0, abl_q}) begin
                pfd_up    <= 1'b0;
                pfd_dn    <= 1'b0;
                abl_cnt_q <= {(ABL_W+1){1'b0}};
            end else begin
                abl_cnt_q <= abl_cnt_q + {{ABL_W{1'b0}}, 1'b1};
            end
        end else begin
            pfd_up <= pfd_up | ref_pulse;
            pfd_dn <= pfd_dn | fb_pulse;
        end
    end

    // ****************************************************************
    // autocalibration sequencer
    // ****************************************************************
    localparam ST_IDLE = 4'h1;
    localparam ST_BAND = 4'h2;
    localparam ST_AMP  = 4'h4;
    localparam ST_DIV  = 4'h8;
    reg [3:0]        st_q;
    reg [2:0]        pfd_cyc_q;
    reg [BAND_W-1:0] bit_q;

    always @(posedge clock) begin
        if (!rst_n) begin
            st_q      <= ST_IDLE;
            pfd_cyc_q <= 3'h0;
            bit_q     <= {BAND_W{1'b0}};
            tune_hold <= 1'b0;
            cal_busy  <= 1'b0;
            band_q    <= {1'b1, {(BAND_W-1){1'b0}}};
            amp_q     <= {AMP_W{1'b0}};
            hr_sel_q  <= {HR_W{1'b0}};
        end else if (cal_start) begin
            st_q      <= ST_BAND;
            tune_hold <= 1'b1;
            cal_busy  <= 1'b1;
            pfd_cyc_q <= 3'h0;
            bit_q     <= {1'b1, {(BAND_W-1){1'b0}}};
            band_q    <= {1'b1, {(BAND_W-1){1'b0}}};
        end else begin
            case (st_q)
                ST_IDLE: cal_busy <= 1'b0;
                ST_BAND: if (ref_pulse) begin
                    if (cal_fast)
                        band_q <= (band_q & ~bit_q) | (bit_q >> 1);
                    else
                        band_q <= band_q | (bit_q >> 1);
                    bit_q     <= bit_q >> 1;
                    pfd_cyc_q <= pfd_cyc_q + 3'h1;
                    if (pfd_cyc_q == `LOSDC_BAND_CYC - 3'h1) begin
                        tune_hold <= 1'b0;
                        amp_q     <= {AMP_W{1'b0}};
                        st_q      <= ST_AMP;
                    end
                end
                ST_AMP: begin
                    if (amp_ok || amp_q == {AMP_W{1'b1}})
                        st_q <= ST_DIV;
                    else
                        amp_q <= amp_q + {{(AMP_W-1){1'b0}}, 1'b1};
                end
                ST_DIV: begin
                    hr_sel_q <= band_q[BAND_W-1:BAND_W-HR_W] % 4'hD;
                    st_q     <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

endmodule // losdc_top

// ### dv/losdc_vco_model.sv
module losdc_vco_model #(
    parameter BAND_W   = 6,
    parameter AMP_W    = 3,
    parameter TGT_BAND = 6'h0B,
    parameter TGT_AMP  = 3'h3
) (
    input  wire logic              clock,    // master clock
    input  wire logic [BAND_W-1:0] band_q,   // band chosen by the block
    input  wire logic [AMP_W-1:0]  amp_q,    // amplitude chosen by the block
    output logic                   vco_clk,  // oscillator stand-in
    output logic                   cal_fast, // above target frequency
    output logic                   amp_ok    // amplitude large enough
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // free running oscillator, edges away from the sampling edge
    // ****
    initial vco_clk = 1'b0;
    always @(negedge clock) begin
        // an unknown start still settles into toggling
        vco_clk <= (vco_clk !== 1'b1);
    end
    assign cal_fast = band_q > TGT_BAND;
    assign amp_ok   = amp_q >= TGT_AMP;
endmodule // losdc_vco_model

// ### dv/losdc_top_asserts.sv
module losdc_top_asserts #(
    parameter BAND_W = 6,
    parameter HR_W   = 4
) (
    input wire logic              clock,     // master clock
    input wire logic              rst_n,     // reset, active low
    input wire logic              wr_en,     // write strobe
    input wire logic [1:0]        wr_addr,   // register select
    input wire logic              ref_pulse, // reference pulse
    input wire logic              pfd_up,    // pump up
    input wire logic              pfd_dn,    // pump down
    input wire logic              tune_hold, // tuning held
    input wire logic [BAND_W-1:0] band_q,    // band
    input wire logic [HR_W-1:0]   hr_sel_q,  // half-rate setting
    input wire logic              lo_i,      // in-phase output
    input wire logic              lo_q,      // quadrature output
    input wire logic              cal_busy   // calibration running
);
    logic [3:0] hcnt_q;
    logic       w3;
    // ****
    // reference pulses seen while tuning is held
    // ****
    assign w3 = wr_en && wr_addr == 2'h3;
    always_ff @(posedge clock) begin
        if (!rst_n || !tune_hold || w3 || $past(w3))
            hcnt_q <= 4'h0;
        else
            hcnt_q <= hcnt_q + {3'h0, ref_pulse};
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_start_answer: assert property (w3 |-> ##2 cal_busy && tune_hold)
        else $error("calibration did not start");
    a_other_quiet: assert property (wr_en && wr_addr != 2'h3 && !cal_busy && !$past(w3) |-> ##2 !cal_busy)
        else $error("calibration started by other register");
    a_hold_quiet: assert property (tune_hold && $past(tune_hold) && $past(tune_hold, 2) |-> !pfd_up && !pfd_dn)
        else $error("pump active during band select");
    a_hold_busy: assert property (tune_hold |-> cal_busy)
        else $error("tuning held outside calibration");
    a_hold_max: assert property (tune_hold |-> hcnt_q <= 4'h5)
        else $error("band select too long");
    a_hold_min: assert property ($fell(tune_hold) |-> hcnt_q == 4'h5)
        else $error("band select too short");
    a_abl_width: assert property (pfd_up && pfd_dn |-> ##[1:8] !(pfd_up && pfd_dn))
        else $error("overlap pulse too wide");
    a_hr_range: assert property (hr_sel_q <= 4'hC)
        else $error("half-rate setting out of range");
    a_quad_alt: assert property ($changed(lo_i) |-> $stable(lo_q))
        else $error("quadrature outputs moved together");
    a_band_idle: assert property (!cal_busy && !$past(cal_busy) |-> $stable(band_q))
        else $error("band changed while idle");
endmodule // losdc_top_asserts
bind losdc_top losdc_top_asserts #(.BAND_W(BAND_W), .HR_W(HR_W)) u_chk (.clock(clock), .rst_n(rst_n),
    .wr_en(wr_en), .wr_addr(wr_addr), .ref_pulse(ref_pulse), .pfd_up(pfd_up), .pfd_dn(pfd_dn),
    .tune_hold(tune_hold), .band_q(band_q), .hr_sel_q(hr_sel_q), .lo_i(lo_i), .lo_q(lo_q), .cal_busy(cal_busy));

// ### dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [13:0] r; logic [12:0] b; logic [4:0] a;} losdc_row_t;
    logic        clock, rst_n, wr_en, vco_clk, cal_fast, amp_ok;
    logic [1:0]  wr_addr;
    logic [23:0] wr_data;
    wire         ref_pulse, fb_pulse, modulus_q, pfd_up, pfd_dn, tune_hold, lo_i, lo_q, cal_busy;
    wire  [5:0]  band_q;
    wire  [2:0]  amp_q;
    wire  [3:0]  hr_sel_q;
    int          error_cnt = 0, compares = 0, per, hi, n;
    // ratios keep update rate and counter ranges legal
    losdc_row_t  rows[3] = '{'{14'h00C8, 13'h0003, 5'h00}, '{14'h00C9, 13'h0004, 5'h03},
                             '{14'h3FFF, 13'h0020, 5'h1F}};
    losdc_top u_dut (.clock(clock), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .vco_clk(vco_clk), .cal_fast(cal_fast), .amp_ok(amp_ok), .ref_pulse(ref_pulse), .fb_pulse(fb_pulse),
        .modulus_q(modulus_q), .pfd_up(pfd_up), .pfd_dn(pfd_dn), .tune_hold(tune_hold), .band_q(band_q),
        .amp_q(amp_q), .hr_sel_q(hr_sel_q), .lo_i(lo_i), .lo_q(lo_q), .cal_busy(cal_busy));
    losdc_vco_model u_vco (.clock(clock), .band_q(band_q), .amp_q(amp_q), .vco_clk(vco_clk),
        .cal_fast(cal_fast), .amp_ok(amp_ok));
    // ****
    // clock, tasks, watchdog
    // ****
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task tick;
        @(posedge clock);
        #1;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task wr(input logic [1:0] ad, input logic [23:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        wr_addr <= ad;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task meas(input bit fb);
        per = 0;
        hi = 0;
        tick;
        while ((fb ? fb_pulse : ref_pulse) !== 1'b1 && per < 40000) begin
            tick;
            per++;
        end
        per = 0;
        do begin
            tick;
            per++;
            hi += int'(modulus_q === 1'b1);
        end while ((fb ? fb_pulse : ref_pulse) !== 1'b1 && per < 40000);
    endtask
    task lo_meas;
        per = 0;
        while (lo_i !== 1'b0 && per < 200) begin
            tick;
            per++;
        end
        while (lo_i !== 1'b1 && per < 200) begin
            tick;
            per++;
        end
        per = 0;
        hi = 0;
        do begin
            tick;
            per++;
            hi += int'(lo_q === 1'b1);
        end while (lo_i !== 1'b0 && per < 200);
        do begin
            tick;
            per++;
            hi += int'(lo_q === 1'b1);
        end while (lo_i !== 1'b1 && per < 200);
    endtask
    task conclude;
        $display("compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #450000;
        error_cnt++;
        conclude;
    end
    // ****
    // main sequence
    // ****
    initial begin
        rst_n = 1'b0;
        wr_en = 1'b0;
        wr_addr = 2'h0;
        wr_data = 24'h000000;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        tick;
        foreach (rows[i]) begin
            wr(2'h0, {10'h000, rows[i].r});
            wr(2'h1, {6'h00, rows[i].b, rows[i].a});
            tick;
            tick;
            chk("cal_busy", cal_busy, 32'h0);
            meas(1'b0);
            meas(1'b0);
            chk("ref period", per, rows[i].r);
            meas(1'b1);
            meas(1'b1);
            chk("fb period", per, 2 * (8 * rows[i].b + rows[i].a));
            chk("modulus high", hi, 18 * rows[i].a);
        end
        $display("divider rows done");
        lo_meas;
        chk("lo period", per, 32'h10);
        chk("lo_q high", hi, 32'h8);
        $display("quadrature test done");
        wr(2'h0, 24'h0000C8);
        wr(2'h2, 24'h000007);
        wr(2'h3, 24'h000000);
        tick;
        tick;
        chk("cal_busy", cal_busy, 32'h1);
        chk("tune_hold", tune_hold, 32'h1);
        wr(2'h3, 24'h000000);
        n = 0;
        hi = 0;
        per = 0;
        while (cal_busy === 1'b1 && per < 20000) begin
            tick;
            per++;
            n += int'(ref_pulse === 1'b1 && tune_hold === 1'b1);
            hi += int'(tune_hold === 1'b1 && (pfd_up !== 1'b0 || pfd_dn !== 1'b0));
        end
        chk("hold pulses", n, 32'h5);
        chk("pump held", hi, 32'h0);
        chk("amp_q", amp_q, 32'h3);
        chk("band_q", band_q, 32'h0B);
        chk("hr range", hr_sel_q <= 4'hC, 32'h1);
        lo_meas;
        chk("lo period", per, 32'h18);
        chk("lo_q high", hi, 32'hC);
        per = 0;
        n = 0;
        while (pfd_up === 1'b1 && pfd_dn === 1'b1 && per < 2000) begin
            tick;
            per++;
        end
        while (!(pfd_up === 1'b1 && pfd_dn === 1'b1) && per < 2000) begin
            tick;
            per++;
        end
        while (pfd_up === 1'b1 && pfd_dn === 1'b1 && n < 40) begin
            tick;
            n++;
        end
        chk("overlap width", n, 32'h8);
        $display("calibration done");
        wr(2'h3, 24'h000000);
        repeat (3) tick;
        @(posedge clock);
        rst_n <= 1'b0;
        tick;
        chk("cal_busy", cal_busy, 32'h0);
        chk("tune_hold", tune_hold, 32'h0);
        chk("band_q", band_q, 32'h20);
        // two reset edges so the sampled history holds only reset values
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        tick;
        $display("reset test done");
        conclude;
    end
endmodule // testbench
